// ### verilog/dbr_pkg.sv
// Package: command codes, bank states and timing constants for the bank rule tracker
package dbr_pkg;

  // Bus widths
  localparam int BANKS      = 8;             // Internal banks
  localparam int BA_W       = 3;             // Bank address width
  localparam int ADDR_W     = 14;            // Address input width
  localparam int MR_COUNT   = 4;             // Mode registers selected by bank address
  localparam int CNT_W      = 8;             // Width of every cycle counter

  // Clock period
  localparam int CLK_PERIOD_PS = 4000;       // 250 MHz core clock

  // Analog times in picoseconds, tMRD in clocks (plain defaults)
  localparam int T_RCD_PS   = 15000;         // Activate to access delay
  localparam int T_RP_PS    = 15000;         // Precharge period
  localparam int T_WR_PS    = 15000;         // Write recovery
  localparam int T_RFC_PS   = 127500;        // Refresh cycle time
  localparam int T_XSNR_PS  = 137500;        // Self refresh exit to command
  localparam int T_MRD_TCK  = 2;             // Mode register set delay in clocks

  // Least times round up to whole clocks
  localparam logic [CNT_W-1:0] RCD_CYC  = CNT_W'((T_RCD_PS  + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] RP_CYC   = CNT_W'((T_RP_PS   + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] WR_CYC   = CNT_W'((T_WR_PS   + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] RFC_CYC  = CNT_W'((T_RFC_PS  + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] XSNR_CYC = CNT_W'((T_XSNR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] MRD_CYC  = CNT_W'(T_MRD_TCK);

  // Mode register 0 field positions
  localparam int MR0_BL_LSB = 0;             // Burst length field, 3 bits
  localparam int MR0_CL_LSB = 4;             // CAS latency field, 3 bits
  localparam int AP_BIT     = 10;            // Auto precharge / precharge all select
  localparam logic [2:0] BL8_CODE = 3'h3;    // Burst length code for eight
  localparam logic [CNT_W-1:0] HALF_BL4 = 8'h02; // Clocks of a four beat burst
  localparam logic [CNT_W-1:0] HALF_BL8 = 8'h04; // Clocks of an eight beat burst
  localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000; // Mode register reset value

  // Decoded command on one clock edge
  typedef enum logic [2:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_LM
  } dbr_cmd_type;

  // Per bank state
  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
  } dbr_bank_state_type;

endpackage : dbr_pkg

// ### verilog/dbr_bank.sv
// One bank state tracker with its own cycle counter
`timescale 1ns/100ps

module dbr_bank
  import dbr_pkg::*;
(
  input  wire logic                      i_clk,       // Core clock
  input  wire logic                      i_nrst,      // Synchronous reset, active low
  input  wire logic                      i_act,       // Accepted activate to this bank
  input  wire logic                      i_rd,        // Accepted read to this bank
  input  wire logic                      i_wr,        // Accepted write to this bank
  input  wire logic                      i_pre,       // Accepted precharge to this bank
  input  wire logic                      i_ap,        // Read or write with auto precharge
  input  wire logic [dbr_pkg::CNT_W-1:0] i_rd_len,    // Clocks of a read burst
  input  wire logic [dbr_pkg::CNT_W-1:0] i_wr_len,    // Clocks from write to last data
  output dbr_pkg::dbr_bank_state_type    o_state      // Present bank state
);

  dbr_bank_state_type     state_reg, state_next;     // Bank state
  logic [CNT_W-1:0]       cnt_reg, cnt_next;         // Clocks left in the state

  // Next state and counter
  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg != '0) ? cnt_reg - 8'h01 : cnt_reg;
    unique case (state_reg)
      BK_IDLE: begin
        if (i_act) begin
          state_next = BK_ACTIVATING;
          cnt_next   = RCD_CYC - 8'h01;
        end
      end
      BK_ACTIVATING: begin
        if (cnt_reg == '0) state_next = BK_ACTIVE;
      end
      BK_ACTIVE, BK_READ, BK_WRITE: begin
        // Burst end returns to row active
        if ((state_reg != BK_ACTIVE) && (cnt_reg == '0)) state_next = BK_ACTIVE;
        if (i_rd) begin
          state_next = i_ap ? BK_READ_AP : BK_READ;
          cnt_next   = i_rd_len - 8'h01;
        end else if (i_wr) begin
          state_next = i_ap ? BK_WRITE_AP : BK_WRITE;
          // Write recovery added only with auto precharge
          cnt_next   = i_ap ? i_wr_len + WR_CYC - 8'h01 : i_wr_len - 8'h01;
        end else if (i_pre) begin
          state_next = BK_PRECHARGING;
          cnt_next   = RP_CYC - 8'h01;
        end
      end
      BK_READ_AP, BK_WRITE_AP: begin
        // Access period ends, precharge period starts
        if (cnt_reg == '0) begin
          state_next = BK_PRECHARGING;
          cnt_next   = RP_CYC - 8'h01;
        end
      end
      BK_PRECHARGING: begin
        // Last precharge sets the period
        if (i_pre) cnt_next = RP_CYC - 8'h01;
        else if (cnt_reg == '0) state_next = BK_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg <= BK_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign o_state = state_reg;

endmodule : dbr_bank

// ### verilog/dbr_rules.sv
// Command decoder and cross bank state tracker for an eight bank DDR2 device
`timescale 1ns/100ps

module dbr_rules
  import dbr_pkg::*;
(
  input  wire logic                       I_CORE_CLK,      // Core clock, 250 MHz
  input  wire logic                       I_NRST,          // Synchronous reset, active low
  input  wire logic                       I_CKE,           // Clock enable
  input  wire logic                       I_CS_N,          // Chip select, active low
  input  wire logic                       I_RAS_N,         // Row strobe, active low
  input  wire logic                       I_CAS_N,         // Column strobe, active low
  input  wire logic                       I_WE_N,          // Write enable, active low
  input  wire logic [dbr_pkg::BA_W-1:0]   I_BA,            // Bank address
  input  wire logic [dbr_pkg::ADDR_W-1:0] I_ADDR,          // Address inputs
  output logic                            O_CMD_ACT,       // Activate taken, pulse
  output logic                            O_CMD_RD,        // Read taken, pulse
  output logic                            O_CMD_WR,        // Write taken, pulse
  output logic                            O_CMD_PRE,       // Precharge taken, pulse
  output logic                            O_CMD_REF,       // Refresh taken, pulse
  output logic                            O_CMD_LM,        // Load mode taken, pulse
  output logic                            O_CMD_AP,        // Auto precharge or all banks
  output logic [dbr_pkg::BA_W-1:0]        O_CMD_BANK,      // Bank of taken act, read, write or precharge
  output logic                            O_CMD_REJECT,    // Command refused, pulse
  output logic [dbr_pkg::BANKS-1:0]       O_BANK_IDLE,     // Per bank idle
  output logic [dbr_pkg::BANKS-1:0]       O_BANK_ACTIVE,   // Per bank row active
  output logic                            O_ALL_IDLE,      // Every bank idle
  output logic                            O_DEV_BUSY,      // tMRD, tRFC or tXSNR running
  output logic                            O_RD_IN_FLIGHT,  // Read data still due
  output logic [dbr_pkg::ADDR_W-1:0]      O_MODE_REG0,     // Mode register 0
  output logic [dbr_pkg::ADDR_W-1:0]      O_MODE_REG1,     // Mode register 1
  output logic [dbr_pkg::ADDR_W-1:0]      O_MODE_REG2,     // Mode register 2
  output logic [dbr_pkg::ADDR_W-1:0]      O_MODE_REG3      // Mode register 3
);

  // Decode and qualification
  dbr_cmd_type            cmd;                        // Command on this edge
  logic                   cke_prev_reg, cke_prev_next; // CKE on the previous edge
  logic                   in_sr_reg, in_sr_next;      // Self refresh entered
  logic                   enabled;                    // Commands may be honoured
  logic                   ap;                         // A10 on this edge

  // Bank tracking
  dbr_bank_state_type     bank_state [BANKS];         // State of each bank
  logic [BANKS-1:0]       sel;                        // Addressed bank, one hot
  logic [BANKS-1:0]       bk_act, bk_rd, bk_wr, bk_pre; // Accepted strobes per bank
  logic [BANKS-1:0]       idle_vec, active_vec;       // Per bank summaries
  logic [BANKS-1:0]       rw_ok, act_ok, pre_ok;      // Per bank legality
  logic                   all_idle;                   // Every bank idle

  // Timing derived from mode register 0
  logic [CNT_W-1:0]       half_bl;                    // Burst clocks, BL/2
  logic [CNT_W-1:0]       cas_lat;                    // CAS latency
  logic [CNT_W-1:0]       wr_lat;                     // Write latency, CL-1
  logic [CNT_W-1:0]       wr_len;                     // Write to last data clocks

  // Shared counters
  logic [CNT_W-1:0]       busy_reg, busy_next;        // Device wide wait
  logic [CNT_W-1:0]       rdf_reg, rdf_next;          // Read data in flight

  // Mode registers
  logic [ADDR_W-1:0]      mode_reg  [MR_COUNT];       // Stored mode registers
  logic [ADDR_W-1:0]      mode_next [MR_COUNT];       // Next mode register values

  // Accepted command and registered outputs
  logic                   take_act, take_rd, take_wr, take_pre, take_ref, take_lm;
  logic                   reject;                     // Refused executable command
  logic [5:0]             pulse_reg, pulse_next;      // act rd wr pre ref lm
  logic                   ap_reg, ap_next;            // Registered A10
  logic [BA_W-1:0]        bank_reg, bank_next;        // Registered bank
  logic                   rej_reg, rej_next;          // Registered refusal

  // Command decode from select lines
  always_comb begin
    cmd = CMD_DESEL;
    if (!I_CS_N) begin
      unique case ({I_RAS_N, I_CAS_N, I_WE_N})
        3'h7: cmd = CMD_NOP;
        3'h3: cmd = CMD_ACT;
        3'h5: cmd = CMD_RD;
        3'h4: cmd = CMD_WR;
        3'h2: cmd = CMD_PRE;
        3'h1: cmd = CMD_REF;
        3'h0: cmd = CMD_LM;
        default: cmd = CMD_NOP;                       // Unused code does nothing
      endcase
    end
  end

  // Bank select and auto precharge bit
  assign ap = I_ADDR[AP_BIT];
  always_comb begin
    sel = '0;
    sel[I_BA] = 1'b1;
  end

  // CKE history and self refresh tracking
  always_comb begin
    cke_prev_next = I_CKE;
    in_sr_next    = in_sr_reg;
    if (cke_prev_reg && !I_CKE && !I_CS_N && (cmd == CMD_REF)) in_sr_next = 1'b1;
    else if (I_CKE) in_sr_next = 1'b0;
  end

  // Rules honoured only with CKE high twice and no wait pending
  assign enabled = cke_prev_reg && I_CKE && (busy_reg == '0);

  // Burst and latency figures from mode register 0
  always_comb begin
    half_bl = (mode_reg[0][MR0_BL_LSB +: 3] == BL8_CODE) ? HALF_BL8 : HALF_BL4;
    cas_lat = CNT_W'(mode_reg[0][MR0_CL_LSB +: 3]);
    wr_lat  = (cas_lat != '0) ? cas_lat - 8'h01 : '0;
    wr_len  = wr_lat + half_bl;
  end

  // Per bank trackers and summaries
  genvar gi;
  generate
    for (gi = 0; gi < BANKS; gi++) begin : g_bank
      dbr_bank u_bank (
        .i_clk    (I_CORE_CLK),
        .i_nrst   (I_NRST),
        .i_act    (bk_act[gi]),
        .i_rd     (bk_rd[gi]),
        .i_wr     (bk_wr[gi]),
        .i_pre    (bk_pre[gi]),
        .i_ap     (ap),
        .i_rd_len (half_bl),
        .i_wr_len (wr_len),
        .o_state  (bank_state[gi])
      );
      // Summaries of this bank
      assign idle_vec[gi]   = (bank_state[gi] == BK_IDLE);
      assign active_vec[gi] = (bank_state[gi] == BK_ACTIVE);
      // Column access needs an open row, no auto precharge pending
      assign rw_ok[gi]  = (bank_state[gi] == BK_ACTIVE) || (bank_state[gi] == BK_READ) ||
                          (bank_state[gi] == BK_WRITE);
      assign act_ok[gi] = idle_vec[gi];
      // Precharge refused during activate and auto precharge access
      assign pre_ok[gi] = !((bank_state[gi] == BK_ACTIVATING) ||
                            (bank_state[gi] == BK_READ_AP) ||
                            (bank_state[gi] == BK_WRITE_AP));
      // Strobes to this bank, plus every bank on a precharge with A10 high
      assign bk_act[gi] = take_act && sel[gi];
      assign bk_rd[gi]  = take_rd && sel[gi];
      assign bk_wr[gi]  = take_wr && sel[gi];
      assign bk_pre[gi] = take_pre && (ap ? pre_ok[gi] : sel[gi]);
    end
  endgenerate

  assign all_idle = &idle_vec;

  // Acceptance of each command against bank and device state
  always_comb begin
    take_act = 1'b0;
    take_rd  = 1'b0;
    take_wr  = 1'b0;
    take_pre = 1'b0;
    take_ref = 1'b0;
    take_lm  = 1'b0;
    reject   = 1'b0;
    if (!I_CS_N && cke_prev_reg && I_CKE) begin
      unique case (cmd)
        CMD_ACT: begin
          take_act = enabled && |(act_ok & sel);
        end
        CMD_RD: begin
          take_rd  = enabled && |(rw_ok & sel);
        end
        CMD_WR: begin
          // Write held off while read data is still due
          take_wr  = enabled && |(rw_ok & sel) && (rdf_reg == '0);
        end
        CMD_PRE: begin
          take_pre = enabled && (ap ? (&pre_ok) : |(pre_ok & sel));
        end
        CMD_REF: begin
          take_ref = enabled && all_idle;
        end
        CMD_LM: begin
          take_lm  = enabled && all_idle;
        end
        default: begin
        end
      endcase
      // Executable command that was not honoured
      reject = (cmd != CMD_NOP) && (cmd != CMD_DESEL) &&
               !(take_act || take_rd || take_wr || take_pre || take_ref || take_lm);
    end
  end

  // Device wide wait and read data tracking
  always_comb begin
    busy_next = (busy_reg != '0) ? busy_reg - 8'h01 : busy_reg;
    rdf_next  = (rdf_reg != '0) ? rdf_reg - 8'h01 : rdf_reg;
    if (take_lm) busy_next = MRD_CYC - 8'h01;
    else if (take_ref) busy_next = RFC_CYC - 8'h01;
    else if (in_sr_reg && I_CKE) busy_next = XSNR_CYC;
    // Read data lasts CL plus the burst
    if (take_rd) rdf_next = cas_lat + half_bl;
  end

  // Mode register load
  always_comb begin
    for (int i = 0; i < MR_COUNT; i++) begin
      mode_next[i] = mode_reg[i];
    end
    // Bank address picks the register, address gives contents
    if (take_lm) mode_next[I_BA[1:0]] = I_ADDR;
  end

  // Registered command report
  always_comb begin
    pulse_next = {take_act, take_rd, take_wr, take_pre, take_ref, take_lm};
    ap_next    = ap_reg;
    bank_next  = bank_reg;
    rej_next   = reject;
    if (take_act || take_rd || take_wr || take_pre) begin
      ap_next   = ap;
      bank_next = I_BA;
    end
  end

  // State registers
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      cke_prev_reg <= 1'b0;
      in_sr_reg    <= 1'b0;
      busy_reg     <= '0;
      rdf_reg      <= '0;
      pulse_reg    <= '0;
      ap_reg       <= 1'b0;
      bank_reg     <= '0;
      rej_reg      <= 1'b0;
      for (int i = 0; i < MR_COUNT; i++) begin
        mode_reg[i] <= MR_RESET;
      end
    end else begin
      cke_prev_reg <= cke_prev_next;
      in_sr_reg    <= in_sr_next;
      busy_reg     <= busy_next;
      rdf_reg      <= rdf_next;
      pulse_reg    <= pulse_next;
      ap_reg       <= ap_next;
      bank_reg     <= bank_next;
      rej_reg      <= rej_next;
      for (int i = 0; i < MR_COUNT; i++) begin
        mode_reg[i] <= mode_next[i];
      end
    end
  end

  // Output drive
  assign {O_CMD_ACT, O_CMD_RD, O_CMD_WR, O_CMD_PRE, O_CMD_REF, O_CMD_LM} = pulse_reg;
  assign O_CMD_AP       = ap_reg;
  assign O_CMD_BANK     = bank_reg;
  assign O_CMD_REJECT   = rej_reg;
  assign O_BANK_IDLE    = idle_vec;
  assign O_BANK_ACTIVE  = active_vec;
  assign O_ALL_IDLE     = all_idle;
  assign O_DEV_BUSY     = (busy_reg != '0);
  assign O_RD_IN_FLIGHT = (rdf_reg != '0);
  assign O_MODE_REG0    = mode_reg[0];
  assign O_MODE_REG1    = mode_reg[1];
  assign O_MODE_REG2    = mode_reg[2];
  assign O_MODE_REG3    = mode_reg[3];

endmodule : dbr_rules

// ### tb/dbr_rules_chk.sv
// Checker: command decode and bank status relations of the bank rule tracker
`timescale 1ns/100ps

module dbr_rules_chk
  import dbr_pkg::*;
(
  input wire logic                I_CORE_CLK,     // Core clock
  input wire logic                I_NRST,         // Reset, active low
  input wire logic                I_CKE,          // Clock enable
  input wire logic                I_CS_N,         // Chip select
  input wire logic                I_RAS_N,        // Row strobe
  input wire logic                I_CAS_N,        // Column strobe
  input wire logic                I_WE_N,         // Write enable
  input wire logic [BA_W-1:0]     I_BA,           // Bank address
  input wire logic [ADDR_W-1:0]   I_ADDR,         // Address
  input wire logic                O_CMD_ACT,      // Activate pulse
  input wire logic                O_CMD_RD,       // Read pulse
  input wire logic                O_CMD_WR,       // Write pulse
  input wire logic                O_CMD_PRE,      // Precharge pulse
  input wire logic                O_CMD_REF,      // Refresh pulse
  input wire logic                O_CMD_LM,       // Load mode pulse
  input wire logic                O_CMD_AP,       // Auto precharge
  input wire logic [BA_W-1:0]     O_CMD_BANK,     // Bank of command
  input wire logic                O_CMD_REJECT,   // Refusal pulse
  input wire logic [BANKS-1:0]    O_BANK_IDLE,    // Per bank idle
  input wire logic [BANKS-1:0]    O_BANK_ACTIVE,  // Per bank active
  input wire logic                O_ALL_IDLE,     // All idle
  input wire logic                O_DEV_BUSY,     // Device wait
  input wire logic                O_RD_IN_FLIGHT, // Read data due
  input wire logic [ADDR_W-1:0]   O_MODE_REG0     // Mode register 0
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  logic [3:0] cmd;           // Select lines as one code
  logic [6:0] pulses;        // Every command answer
  logic       cke_prev_reg;  // Clock enable on the last edge
  logic       cke_prev_next; // Its next value
  logic       live;          // Commands may be taken

  assign cmd    = {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N};
  assign pulses = {O_CMD_ACT, O_CMD_RD, O_CMD_WR, O_CMD_PRE, O_CMD_REF, O_CMD_LM, O_CMD_REJECT};
  assign live   = I_CKE && cke_prev_reg;

  // Previous clock enable, cleared by reset like the tracker's own
  always_comb cke_prev_next = I_NRST ? I_CKE : 1'b0;
  always_ff @(posedge I_CORE_CLK) cke_prev_reg <= cke_prev_next;

  a_one_answer: assert property ($onehot0(pulses))
    else $error("two answers at once");
  a_desel_quiet: assert property (I_CS_N |=> pulses == 7'h00)
    else $error("deselect produced an answer");
  a_nop_quiet: assert property (cmd == 4'h7 |=> pulses == 7'h00)
    else $error("nop produced an answer");
  a_cke_gate: assert property (!live |=> pulses == 7'h00)
    else $error("command taken with clock enable low");
  a_act_taken: assert property (cmd == 4'h3 && live && !O_DEV_BUSY
    && O_BANK_IDLE[I_BA] |=> O_CMD_ACT && O_CMD_BANK == $past(I_BA))
    else $error("legal activate not taken");
  a_act_opens: assert property (O_CMD_ACT |-> !O_BANK_IDLE[O_CMD_BANK]
    ##4 O_BANK_ACTIVE[$past(O_CMD_BANK, 4)]) else $error("row not active after delay");
  a_rd_ap_hold: assert property (O_CMD_RD && O_CMD_AP && O_MODE_REG0[2:0] != 3'h3
    |-> ##5 !O_BANK_IDLE[$past(O_CMD_BANK, 5)]) else $error("auto precharge bank idle early");
  a_wr_after_rd: assert property (O_CMD_WR |-> !$past(O_RD_IN_FLIGHT))
    else $error("write taken while read data due");
  a_all_idle_only: assert property (O_CMD_REF || O_CMD_LM |-> $past(O_ALL_IDLE))
    else $error("refresh or load mode with busy bank");
  a_lm_loads: assert property (O_CMD_LM && $past(I_BA[1:0]) == 2'h0
    |-> O_MODE_REG0 == $past(I_ADDR) && O_DEV_BUSY) else $error("mode register 0 not loaded");
  a_busy_refuse: assert property (O_DEV_BUSY && live && !I_CS_N && cmd != 4'h7
    |=> O_CMD_REJECT) else $error("command not refused while busy");
  a_idle_and: assert property (O_ALL_IDLE == &O_BANK_IDLE)
    else $error("all idle disagrees with banks");
  a_pre_holds: assert property (O_CMD_PRE && !O_CMD_AP && !O_BANK_IDLE[O_CMD_BANK]
    |-> ##3 !O_BANK_IDLE[$past(O_CMD_BANK, 3)]) else $error("bank idle before precharge time");

  c_act: cover property (O_CMD_ACT);
  c_rd_ap: cover property (O_CMD_RD && O_CMD_AP);
  c_lm: cover property (O_CMD_LM);
  c_reject: cover property (O_CMD_REJECT);
endmodule : dbr_rules_chk

bind dbr_rules dbr_rules_chk u_chk (.I_CORE_CLK, .I_NRST, .I_CKE, .I_CS_N, .I_RAS_N,
  .I_CAS_N, .I_WE_N, .I_BA, .I_ADDR, .O_CMD_ACT, .O_CMD_RD, .O_CMD_WR, .O_CMD_PRE,
  .O_CMD_REF, .O_CMD_LM, .O_CMD_AP, .O_CMD_BANK, .O_CMD_REJECT, .O_BANK_IDLE,
  .O_BANK_ACTIVE, .O_ALL_IDLE, .O_DEV_BUSY, .O_RD_IN_FLIGHT, .O_MODE_REG0);

// ### tb/dbr_ctl_model.sv
// Controller model: drives clock enable and command lines toward the tracker
`timescale 1ns/100ps

module dbr_ctl_model
  import dbr_pkg::*;
(
  output logic                       o_cke,   // Clock enable
  output logic                       o_cs_n,  // Chip select
  output logic                       o_ras_n, // Row strobe
  output logic                       o_cas_n, // Column strobe
  output logic                       o_we_n,  // Write enable
  output logic [dbr_pkg::BA_W-1:0]   o_ba,    // Bank address
  output logic [dbr_pkg::ADDR_W-1:0] o_addr   // Address
);
  // One command per call; the caller times it on the falling edge and
  // spaces commands per bank state and cross bank delays
  task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b,
                       input logic [13:0] a);
    o_cke  = k;
    o_cs_n = c[3];
    if (c[3]) begin
      // Not selected: other lines flip so no stale level lingers
      {o_ras_n, o_cas_n, o_we_n} = ~{o_ras_n, o_cas_n, o_we_n};
      o_ba   = ~o_ba;
      o_addr = ~o_addr;
    end else begin
      {o_ras_n, o_cas_n, o_we_n} = c[2:0];
      o_ba   = b;
      o_addr = a;
    end
  endtask : issue

  // Idle lines from time zero
  initial issue(1'b1, 4'h7, 3'h0, 14'h0000);
endmodule : dbr_ctl_model

// ### tb/tb_dbr_rules.sv
// Bench: command table, then timing, mode register and reset cases
`timescale 1ns/100ps

module tb_dbr_rules;
  import dbr_pkg::*;

  typedef struct packed {
    logic k; logic [3:0] c; logic [2:0] b; logic [13:0] a; logic [6:0] e;
  } dbr_row_type;

  logic             clk = 1'b0;   // Core clock
  logic             nrst = 1'b0;  // Reset, active low
  logic             cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0]       ba, bank;
  logic [13:0]      addr;
  logic             act, rd, wr, pre, rf, lm, ap, rej, all_idle, busy, rif;
  logic [7:0]       idle, active;
  logic [13:0]      mr [4];       // Mode registers seen
  logic [6:0]       pulses;       // Answers as one vector
  dbr_row_type      rows [$];     // Ordinary cases
  int               err_count = 0;
  int               cmp_count = 0;

  assign pulses = {act, rd, wr, pre, rf, lm, rej};

  // 250 MHz clock
  initial forever #2 clk = ~clk;

  dbr_ctl_model u_ctl (.o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_ba(ba), .o_addr(addr));

  dbr_rules dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_CKE(cke), .I_CS_N(cs_n),
    .I_RAS_N(ras_n), .I_CAS_N(cas_n), .I_WE_N(we_n), .I_BA(ba), .I_ADDR(addr),
    .O_CMD_ACT(act), .O_CMD_RD(rd), .O_CMD_WR(wr), .O_CMD_PRE(pre), .O_CMD_REF(rf),
    .O_CMD_LM(lm), .O_CMD_AP(ap), .O_CMD_BANK(bank), .O_CMD_REJECT(rej),
    .O_BANK_IDLE(idle), .O_BANK_ACTIVE(active), .O_ALL_IDLE(all_idle), .O_DEV_BUSY(busy),
    .O_RD_IN_FLIGHT(rif), .O_MODE_REG0(mr[0]), .O_MODE_REG1(mr[1]), .O_MODE_REG2(mr[2]),
    .O_MODE_REG3(mr[3]));

  // Compare one result
  task chk(input string n, input logic [13:0] e, input logic [13:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task print_verdict;
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task r(input logic k, input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
         input logic [6:0] e);
    rows.push_back('{k, c, b, a, e});
  endtask : r

  // One command with clock enable high, then one cycle
  task go(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    u_ctl.issue(1'b1, c, b, a);
    @(negedge clk);
  endtask : go

  // Bank still out of idle n-1 cycles after the answer, idle at n
  task idle_at(input int b, input int n);
    repeat (n - 1) go(4'h7, 3'h0, 14'h0000);
    chk("idle_early", 14'h0000, 14'(idle[b]));
    go(4'h7, 3'h0, 14'h0000);
    chk("idle_late", 14'h0001, 14'(idle[b]));
  endtask : idle_at

  // Hang guard
  initial begin
    #20000;
    err_count++;
    print_verdict();
  end

  initial begin
    // Answers: act 40 rd 20 wr 10 pre 08 ref 04 lm 02 reject 01
    r(1, 4'h7, 0, 14'h0000, 7'h00); r(1, 4'h0, 0, 14'h0032, 7'h02);
    r(1, 4'h3, 2, 14'h0000, 7'h01); r(1, 4'h7, 0, 14'h0000, 7'h00);
    r(1, 4'h7, 0, 14'h0000, 7'h00); r(1, 4'hA, 2, 14'h0000, 7'h00);
    r(0, 4'h3, 2, 14'h0000, 7'h00); r(1, 4'h3, 2, 14'h0000, 7'h00);
    r(1, 4'h3, 2, 14'h0000, 7'h40); r(1, 4'h5, 2, 14'h0000, 7'h01);
    r(1, 4'h7, 0, 14'h0000, 7'h00); r(1, 4'h7, 0, 14'h0000, 7'h00);
    r(1, 4'h7, 0, 14'h0000, 7'h00); r(1, 4'h5, 2, 14'h0000, 7'h20);
    r(1, 4'h4, 2, 14'h0000, 7'h01); r(1, 4'h1, 0, 14'h0000, 7'h01);
    r(1, 4'h3, 5, 14'h0000, 7'h40); r(1, 4'h2, 2, 14'h0000, 7'h08);
    r(1, 4'h0, 1, 14'h0000, 7'h01); r(1, 4'h2, 5, 14'h0000, 7'h01);
    r(1, 4'h2, 0, 14'h0400, 7'h01);
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    chk("idle_reset", 14'h00FF, 14'(idle));
    foreach (rows[i]) begin
      u_ctl.issue(rows[i].k, rows[i].c, rows[i].b, rows[i].a);
      @(negedge clk);
      chk("answer", 14'(rows[i].e), 14'(pulses));
    end
    repeat (6) go(4'h7, 3'h0, 14'h0000);
    go(4'h5, 3'h5, 14'h0400);
    chk("rd_ap", 14'h0003, 14'({rd, ap}));
    idle_at(5, 6);
    go(4'h3, 3'h1, 14'h0000);
    repeat (4) go(4'h7, 3'h0, 14'h0000);
    go(4'h4, 3'h1, 14'h0400);
    chk("wr_ap", 14'h0003, 14'({wr, ap}));
    idle_at(1, 12);
    for (int i = 3; i >= 0; i--) begin
      go(4'h0, 3'(i), 14'h0042 + 14'(i) * 14'h0100);
      chk("mode_reg", 14'h0042 + 14'(i) * 14'h0100, mr[i]);
      repeat (2) go(4'h7, 3'h0, 14'h0000);
    end
    // Reserved code acts as no operation
    go(4'h6, 3'h0, 14'h0000);
    chk("reserved", 14'h0000, 14'(pulses));
    // Refresh holds off commands for its cycle time
    go(4'h1, 3'h0, 14'h0000);
    chk("refresh", 14'h0004, 14'(pulses));
    repeat (RFC_CYC - 2) go(4'h7, 3'h0, 14'h0000);
    go(4'h3, 3'h6, 14'h0000);
    chk("rfc_wait", 14'h0001, 14'(pulses));
    // Self refresh entry, then the exit wait
    u_ctl.issue(1'b0, 4'h1, 3'h0, 14'h0000);
    @(negedge clk);
    chk("sr_entry", 14'h0000, 14'(pulses));
    repeat (XSNR_CYC) go(4'h7, 3'h0, 14'h0000);
    go(4'h3, 3'h6, 14'h0000);
    chk("xsnr_wait", 14'h0001, 14'(pulses));
    go(4'h3, 3'h6, 14'h0000);
    chk("xsnr_done", 14'h0040, 14'(pulses));
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk("idle_rerst", 14'h00FF, 14'(idle));
    chk("mr_rerst", 14'h0000, mr[0]);
    chk("pulse_rerst", 14'h0000, 14'(pulses));
    nrst = 1'b1;
    go(4'h7, 3'h0, 14'h0000);
    print_verdict();
  end
endmodule : tb_dbr_rules
